// File: dv/isa_core_checker.sv
// port assertions for the instruction-set core
`timescale 1ns/1ps
`default_nettype none
module isa_core_checker (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic mem_ack_i,
	input wire logic irq_req_i,
	input wire logic [2:0] irq_level_i,
	input wire logic [15:0] pc_o,
	input wire logic mem_req_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic irq_ack_o,
	input wire logic [2:0] irq_ack_level_o,
	input wire logic periph_wr_o,
	input wire logic [7:0] periph_addr_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);
	// ----------------
	// assertions
	// ----------------
	ack_pulse_a: assert property (irq_ack_o |=> !irq_ack_o)
		else $error("interrupt taken twice in a row");
	ack_cause_a: assert property (!irq_req_i |=> !irq_ack_o)
		else $error("interrupt taken without a request");
	lvl_match_a: assert property (irq_ack_o |->
		irq_ack_level_o == $past(irq_level_i))
		else $error("taken level differs from request");
	periph_win_a: assert property (periph_wr_o |->
		periph_addr_o >= 8'he0)
		else $error("peripheral write outside window");
	req_hold_a: assert property (mem_req_o && !mem_ack_i |=>
		mem_req_o && $stable(mem_addr_o))
		else $error("memory request dropped before answer");
	req_drop_a: assert property (mem_req_o && mem_ack_i |=>
		!mem_req_o)
		else $error("memory request held after answer");
	pc_still_a: assert property (mem_req_o && !mem_ack_i |=>
		$stable(pc_o))
		else $error("pc moved during memory wait");
	mem_no_irq_a: assert property (mem_req_o |-> !irq_ack_o)
		else $error("interrupt taken during memory wait");
	irq_c: cover property (irq_ack_o);
	periph_c: cover property (periph_wr_o);
	mem_c: cover property (mem_req_o && mem_ack_i);
endmodule // isa_core_checker
bind mcu_instruction_set_core isa_core_checker chk_u (
	.clock_i(clock_i),
	.nrst_i(nrst_i),
	.mem_ack_i(mem_ack_i),
	.irq_req_i(irq_req_i),
	.irq_level_i(irq_level_i),
	.pc_o(pc_o),
	.mem_req_o(mem_req_o),
	.mem_addr_o(mem_addr_o),
	.irq_ack_o(irq_ack_o),
	.irq_ack_level_o(irq_ack_level_o),
	.periph_wr_o(periph_wr_o),
	.periph_addr_o(periph_addr_o)
);
`default_nettype wire

// File: dv/mem_model.sv
// data and program memory answering the core
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic req_i,
	input wire logic [15:0] addr_i,
	input wire logic [3:0] lat_i,
	output logic ack_o,
	output logic [7:0] rdata_o
);
	logic [3:0] cnt;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt <= 4'h0;
			ack_o <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o;
			if (req_i && !ack_o) begin
				if (cnt == lat_i) begin
					ack_o <= 1'b1;
					rdata_o <= addr_i[7:0] ^ 8'h5a;
					cnt <= 4'h0;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
endmodule // mem_model
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the instruction-set core
`timescale 1ns/1ps
`default_nettype none
module tb_top import isa_core_pkg::*;;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic instr_valid_i = 1'b0;
	logic [39:0] instr_i = 40'h0;
	logic mem_ack_i, irq_req_i = 1'b0, mem_req_o, mem_write_o, mem_prog_o;
	logic [7:0] mem_rdata_i, mem_wdata_o, periph_addr_o, periph_wdata_o;
	logic [2:0] irq_level_i = 3'h0, irq_ack_level_o;
	logic [15:0] pc_o, mem_addr_o;
	logic irq_ack_o, periph_wr_o, idle_o, stop_o, illegal_o;
	logic [3:0] lat = 4'h0;
	int fails = 0;
	int checked = 0;
	mcu_instruction_set_core dut_u (.clock_i(clock_i), .nrst_i(nrst_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
		.irq_req_i(irq_req_i), .irq_level_i(irq_level_i), .pc_o(pc_o),
		.mem_req_o(mem_req_o), .mem_write_o(mem_write_o),
		.mem_prog_o(mem_prog_o), .mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o), .irq_ack_o(irq_ack_o),
		.irq_ack_level_o(irq_ack_level_o), .periph_wr_o(periph_wr_o),
		.periph_addr_o(periph_addr_o), .periph_wdata_o(periph_wdata_o),
		.idle_o(idle_o), .stop_o(stop_o), .illegal_o(illegal_o));
	mem_model mem_u (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(mem_req_o),
		.addr_i(mem_addr_o), .lat_i(lat), .ack_o(mem_ack_i),
		.rdata_o(mem_rdata_i));
	initial begin
		forever #2 clock_i = ~clock_i;
	end
	// ----------------
	// shared tasks
	// ----------------
	task test_done;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] got, exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task run(input op_e op, input logic [7:0] md, d, s, ds);
		@(negedge clock_i);
		instr_i = {op, md, d, s, ds};
		instr_valid_i = 1'b1;
		@(negedge clock_i);
		instr_valid_i = 1'b0;
	endtask
	task alu(input op_e op, input logic [7:0] md, a, b, e);
		run(OP_LD, 8'h05, 8'he6, a, 8'h00);
		run(op, md, 8'he6, b, 8'h00);
		chk("alu_result", 16'(periph_wdata_o), 16'(e));
	endtask
	task mem(input op_e op, input logic [15:0] a, input logic p, l);
		int n;
		lat = 4'(l) * 4'h3;
		run(OP_CLR, 8'h00, 8'he7, 8'h00, 8'h00);
		run(op, 8'h00, 8'he7, 8'hc2, 8'h00);
		chk("mem_req", 16'(mem_req_o), 16'h0001);
		chk("mem_addr", mem_addr_o, a);
		chk("mem_prog", 16'(mem_prog_o), 16'(p));
		n = 0;
		while (mem_req_o === 1'b1 && n < 30) begin
			@(negedge clock_i);
			n++;
		end
		repeat (2) @(negedge clock_i);
		chk("load_data", 16'(periph_wdata_o), 16'(a[7:0] ^ 8'h5a));
	endtask
	task irq(input logic [2:0] l, input logic ea, input logic [15:0] ep);
		@(negedge clock_i);
		irq_req_i = 1'b1;
		irq_level_i = l;
		@(negedge clock_i);
		irq_req_i = 1'b0;
		chk("irq_ack", 16'(irq_ack_o), 16'(ea));
		if (ea) begin
			chk("irq_pc", pc_o, ep);
			chk("irq_level", 16'(irq_ack_level_o), 16'(l));
		end
	endtask
	// ----------------
	// scenarios
	// ----------------
	task t_periph;
		run(OP_LD, 8'h05, 8'he5, 8'h3c, 8'h00);
		chk("periph_wr", 16'(periph_wr_o), 16'h0001);
		chk("periph_addr", 16'(periph_addr_o), 16'h00e5);
		chk("periph_data", 16'(periph_wdata_o), 16'h003c);
		chk("pc_step", pc_o, 16'h0105);
		run(op_e'(8'hff), 8'h00, 8'h00, 8'h00, 8'h00);
		chk("illegal", 16'(illegal_o), 16'h0001);
		$display("test periph done");
	endtask
	task t_alu;
		alu(OP_ADD, 8'h05, 8'h07, 8'h05, 8'h0c);
		alu(OP_SUB, 8'h05, 8'h07, 8'h09, 8'hfe);
		alu(OP_AND, 8'h05, 8'h3c, 8'h0f, 8'h0c);
		alu(OP_XOR, 8'h05, 8'h3c, 8'h0f, 8'h33);
		alu(OP_COM, 8'h00, 8'h5a, 8'h00, 8'ha5);
		alu(OP_INC, 8'h00, 8'hff, 8'h00, 8'h00);
		alu(OP_ROL, 8'h00, 8'h81, 8'h00, 8'h03);
		alu(OP_ROR, 8'h00, 8'h81, 8'h00, 8'hc0);
		alu(OP_SHRA, 8'h00, 8'h81, 8'h00, 8'hc0);
		alu(OP_NIBSWAP, 8'h00, 8'h5c, 8'h00, 8'hc5);
		alu(OP_BSET, 8'h30, 8'h00, 8'h00, 8'h08);
		alu(OP_BCLR, 8'h00, 8'hff, 8'h00, 8'hfe);
		alu(OP_BCOM, 8'h70, 8'h00, 8'h00, 8'h80);
		alu(OP_TEST, 8'h05, 8'h0f, 8'hf0, 8'h0f);
		alu(OP_ADD, 8'h05, 8'h09, 8'h08, 8'h11);
		run(OP_DECFIX, 8'h00, 8'he6, 8'h00, 8'h00);
		chk("bcd_fix", 16'(periph_wdata_o), 16'h0017);
		$display("test alu done");
	endtask
	task t_mem;
		run(OP_LD, 8'h05, 8'hc2, 8'h12, 8'h00);
		run(OP_LD, 8'h05, 8'hc3, 8'h34, 8'h00);
		mem(OP_LDX_PREINC, 16'h1235, 1'b0, 1'b1);
		mem(OP_LDP_POSTDEC, 16'h1235, 1'b1, 1'b0);
		mem(OP_LDP, 16'h1234, 1'b1, 1'b1);
		run(OP_LDX, 8'h08, 8'he6, 8'hc2, 8'h00);
		chk("mem_write", 16'(mem_write_o), 16'h0001);
		chk("mem_wdata", 16'(mem_wdata_o), 16'h0017);
		repeat (8) @(negedge clock_i);
		$display("test mem done");
	endtask
	task t_irq;
		irq(3'h3, 1'b0, 16'h0000);
		run(OP_INTON, 8'h00, 8'h00, 8'h00, 8'h00);
		irq(3'h3, 1'b1, 16'h0006);
		irq(3'h3, 1'b0, 16'h0000);
		run(OP_LD, 8'h05, 8'hda, 8'h20, 8'h00);
		run(OP_LD, 8'h05, 8'hdb, 8'h40, 8'h00);
		run(OP_LD, 8'h05, 8'hde, 8'h0d, 8'h00);
		irq(3'h3, 1'b1, 16'h0006);
		run(OP_LD, 8'h05, 8'hde, 8'h0e, 8'h00);
		run(OP_INTOFF, 8'h00, 8'h00, 8'h00, 8'h00);
		irq(3'h3, 1'b0, 16'h0000);
		run(OP_INTON, 8'h00, 8'h00, 8'h00, 8'h00);
		irq(3'h3, 1'b1, 16'h2040);
		run(OP_IRET, 8'h00, 8'h00, 8'h00, 8'h00);
		chk("fast_ret", pc_o, 16'h0015);
		// fresh start address after fast service
		run(OP_LD, 8'h05, 8'hdb, 8'h80, 8'h00);
		irq(3'h3, 1'b1, 16'h2080);
		run(OP_IRET, 8'h00, 8'h00, 8'h00, 8'h00);
		run(OP_IDLE, 8'h00, 8'h00, 8'h00, 8'h00);
		chk("idle", 16'(idle_o), 16'h0001);
		irq(3'h2, 1'b1, 16'h0004);
		chk("idle_wake", 16'(idle_o), 16'h0000);
		run(OP_INTON, 8'h00, 8'h00, 8'h00, 8'h00);
		run(OP_STOP, 8'h00, 8'h00, 8'h00, 8'h00);
		chk("stop", 16'(stop_o), 16'h0001);
		irq(3'h2, 1'b1, 16'h0004);
		chk("stop_wake", 16'(stop_o), 16'h0000);
		$display("test irq done");
	endtask
	initial begin
		#16000;
		fails++;
		test_done();
	end
	initial begin
		repeat (20) @(negedge clock_i);
		nrst_i = 1'b1;
		t_periph();
		t_alu();
		t_mem();
		t_irq();
		test_done();
	end
endmodule // tb_top
`default_nettype wire

// File: rtl/isa_core_pkg.sv
// types of the instruction-set core
package isa_core_pkg;
	typedef enum logic [7:0] {
		OP_CLR, OP_LD, OP_LDBIT, OP_LDX, OP_LDP, OP_LDX_POSTDEC,
		OP_LDP_POSTDEC, OP_LDX_POSTINC, OP_LDP_POSTINC, OP_LDX_PREDEC,
		OP_LDP_PREDEC, OP_LDX_PREINC, OP_LDP_PREINC, OP_LDWORD, OP_POP,
		OP_UPOP_DN, OP_UPOP_UP, OP_PUSH, OP_UPUSH_DN, OP_UPUSH_UP,
		OP_ADDC, OP_ADD, OP_CMP, OP_DECFIX, OP_DEC, OP_WDEC, OP_DIVIDE,
		OP_INC, OP_WINC, OP_PRODUCT, OP_SUBC, OP_SUB,
		OP_AND, OP_COM, OP_OR, OP_XOR,
		OP_BITJ_F, OP_BITJ_T, OP_CALL, OP_CMPJ_EQ, OP_CMPJ_NE, OP_LOOPDN,
		OP_ENTER, OP_EXIT, OP_IRET, OP_JUMP, OP_JREL, OP_NEXT, OP_RET,
		OP_WAITI, OP_BAND, OP_BCMP, OP_BCOM, OP_BCLR, OP_BSET, OP_BOR,
		OP_BXOR, OP_TESTINV, OP_TEST, OP_ROL, OP_ROLC, OP_ROR, OP_RORC,
		OP_SHRA, OP_NIBSWAP, OP_CCF, OP_INTOFF, OP_INTON, OP_IDLE, OP_NOP,
		OP_RCF, OP_BANK0, OP_BANK1, OP_SCF, OP_SETRP, OP_SETRP0, OP_SETRP1,
		OP_STOP
	} op_e;
	typedef enum logic [2:0] {
		MODE_REG, MODE_IND, MODE_IDX, MODE_DIR, MODE_REL, MODE_IMM, MODE_IND_A
	} amode_e;
	typedef enum logic [2:0] {
		S_RUN = 3'b001,
		S_MEM = 3'b010,
		S_WAIT = 3'b100
	} state_e;
endpackage

// File: rtl/isa_core_regs.svh
// register-file locations, field positions and constants of the core
`ifndef ISA_CORE_REGS_SVH
`define ISA_CORE_REGS_SVH
`define RF_WORDS 256
`define FLAGS_ADDR 8'hd5
`define RP0_ADDR 8'hd6
`define RP1_ADDR 8'hd7
`define SP_ADDR 8'hd9
`define IPH_ADDR 8'hda
`define IPL_ADDR 8'hdb
`define SYM_ADDR 8'hde
`define PERIPH_BASE 8'he0
`define RP0_RESET 8'hc0
`define RP1_RESET 8'hc8
`define RP_MASK 8'hf8
`define RP_PAIR_MASK 8'hf0
`define RP_HALF 8'h08
`define WR_MARK 4'hc
`define SYM_GIE 0
`define SYM_FIE 1
`define SYM_LVL_LO 2
`define SYM_LVL_HI 4
`define F_C 7
`define F_Z 6
`define F_S 5
`define F_V 4
`define F_D 3
`define F_H 2
`define F_FIS 1
`define F_BA 0
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define BYTE_TWO 8'h02
`define BYTE_THREE 8'h03
`define WORD_ONE 16'h0001
`define INSTR_BYTES 16'h0005
`define RESET_PC 16'h0100
`define VEC_BASE 16'h0000
`define BCD_LO 8'h06
`define BCD_HI 8'h60
`define BCD_DIG 4'h9
`define BCD_MAX 8'h99
`define CC_ALWAYS 4'h8
`define CC_EQ 4'h6
`define CC_NE 4'he
`define CC_C 4'h7
`define CC_NC 4'hf
`define CC_MI 4'h5
`define CC_PL 4'hd
`endif

// File: rtl/mcu_instruction_set_core.sv
// instruction decode and execute core with register file
`timescale 1ns/1ps
`default_nettype none
`include "isa_core_regs.svh"

// Summary of operation
// - system mode bit 1 and global bit 0 both gate fast interrupts
// - global on/off instructions gate every interrupt
// - seventy-eight instructions in seven groups
// - bits, bytes, bcd digits and words
// - bit 0 is least significant, 7 highest
// - 8-bit register or 4-bit working address
// - register pairs form 16-bit words, addresses
// - seven explicit addressing modes
// - peripherals are plain register-file locations
// - full 8-bit alu with multiply, divide
// - single-step word increment and decrement
// - any bit set, cleared, complemented, tested
// - data/program memory loads with pointer stepping
// - user stack push/pop, both directions
// - bit test with relative branch
// - compare, step pointer, branch on (in)equality
// - loop decrements register, branches if nonzero
// - rotates with/without carry, shift, swap
// - masked tests touching only flags
// - decimal adjust after binary add or subtract
// - bits 4..2 select fast interrupt level
module mcu_instruction_set_core import isa_core_pkg::*; (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic instr_valid_i,
	input wire logic [39:0] instr_i,
	input wire logic mem_ack_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic irq_req_i,
	input wire logic [2:0] irq_level_i,
	output logic [15:0] pc_o,
	output logic mem_req_o,
	output logic mem_write_o,
	output logic mem_prog_o,
	output logic [15:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	output logic irq_ack_o,
	output logic [2:0] irq_ack_level_o,
	output logic periph_wr_o,
	output logic [7:0] periph_addr_o,
	output logic [7:0] periph_wdata_o,
	output logic idle_o,
	output logic stop_o,
	output logic illegal_o
);
	logic [7:0] rf_reg [`RF_WORDS];
	logic [7:0] rf_next [`RF_WORDS];
	state_e state_reg, state_next;
	logic [15:0] pc_reg, pc_next, maddr_reg, maddr_next;
	logic [7:0] fprime_reg, fprime_next, mwd_reg, mwd_next;
	logic [7:0] mdst_reg, mdst_next, pa_reg, pa_next, pd_reg, pd_next;
	logic mreq_reg, mreq_next, mwr_reg, mwr_next, mprog_reg, mprog_next;
	logic ack_reg, ack_next, pw_reg, pw_next, ill_reg, ill_next;
	logic idle_reg, idle_next, stop_reg, stop_next;
	logic [2:0] lvl_reg, lvl_next;
	op_e op;
	amode_e am;
	logic [7:0] dst, src, disp, fl, system_mode_reg, sp, daddr, dv, sra, saddr, sv;
	logic [15:0] ip, dpair, spair, brt, target, ptr, w;
	logic [8:0] add9, sub9;
	logic [4:0] hadd, hsub;
	logic cin, take, fast, fwe, wen, bitv;
	logic [7:0] f, wd, wa, r, mask, adj, t;

	assign op = op_e'(instr_i[39:32]);
	assign am = amode_e'(instr_i[26:24]);
	assign dst = instr_i[23:16];
	assign src = instr_i[15:8];
	assign disp = instr_i[7:0];

	function automatic logic [7:0] wreg(input logic [3:0] n);
		wreg = n[3] ? {rf_reg[`RP1_ADDR][7:3], n[2:0]} :
			{rf_reg[`RP0_ADDR][7:3], n[2:0]};
	endfunction

	function automatic logic [7:0] ea(input logic [7:0] x);
		ea = (x[7:4] == `WR_MARK) ? wreg(x[3:0]) : x;
	endfunction

	function automatic logic cond_ok(input logic [3:0] cc, input logic [7:0] g);
		case (cc)
			`CC_ALWAYS: cond_ok = 1'b1;
			`CC_EQ: cond_ok = g[`F_Z];
			`CC_NE: cond_ok = ~g[`F_Z];
			`CC_C: cond_ok = g[`F_C];
			`CC_NC: cond_ok = ~g[`F_C];
			`CC_MI: cond_ok = g[`F_S];
			`CC_PL: cond_ok = ~g[`F_S];
			default: cond_ok = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// operand decode
	// ------------------------------------------------------------
	always_comb begin
		fl = rf_reg[`FLAGS_ADDR];
		system_mode_reg = rf_reg[`SYM_ADDR];
		sp = rf_reg[`SP_ADDR];
		ip = {rf_reg[`IPH_ADDR], rf_reg[`IPL_ADDR]};
		daddr = ea(dst);
		dv = rf_reg[daddr];
		dpair = {dv, rf_reg[daddr + `BYTE_ONE]};
		sra = ea(src);
		spair = {rf_reg[sra], rf_reg[sra + `BYTE_ONE]};
		case (am)
			MODE_IND: saddr = rf_reg[sra];
			MODE_IDX: saddr = src + rf_reg[wreg(instr_i[31:28])];
			default: saddr = sra;
		endcase
		sv = (am == MODE_IMM) ? src : rf_reg[saddr];
		brt = pc_reg + `INSTR_BYTES + {{8{disp[7]}}, disp};
		case (am)
			MODE_DIR: target = {src, disp};
			MODE_IND_A: target = spair;
			default: target = brt;
		endcase
		cin = (op == OP_ADDC || op == OP_SUBC) & fl[`F_C];
		add9 = {1'b0, dv} + {1'b0, sv} + {8'h00, cin};
		sub9 = {1'b0, dv} - {1'b0, sv} - {8'h00, cin};
		hadd = {1'b0, dv[3:0]} + {1'b0, sv[3:0]} + {4'h0, cin};
		hsub = {1'b0, dv[3:0]} - {1'b0, sv[3:0]} - {4'h0, cin};
		mask = 8'(`BYTE_ONE << instr_i[30:28]);
		bitv = sv[instr_i[30:28]];
		ptr = spair;
		case (op)
			OP_LDX_POSTDEC, OP_LDP_POSTDEC, OP_LDX_PREDEC, OP_LDP_PREDEC:
				ptr = spair - `WORD_ONE;
			OP_LDX_POSTINC, OP_LDP_POSTINC, OP_LDX_PREINC, OP_LDP_PREINC:
				ptr = spair + `WORD_ONE;
			default: ptr = spair;
		endcase
		// global enable gates fast ones too
		take = irq_req_i & system_mode_reg[`SYM_GIE] & ~fl[`F_FIS];
		fast = system_mode_reg[`SYM_FIE] & (irq_level_i == system_mode_reg[`SYM_LVL_HI:`SYM_LVL_LO]);
	end

	// ------------------------------------------------------------
	// execute
	// ------------------------------------------------------------
	always_comb begin
		rf_next = rf_reg;
		state_next = state_reg;
		pc_next = pc_reg;
		fprime_next = fprime_reg;
		mreq_next = mreq_reg;
		mwr_next = mwr_reg;
		mprog_next = mprog_reg;
		maddr_next = maddr_reg;
		mwd_next = mwd_reg;
		mdst_next = mdst_reg;
		ack_next = 1'b0;
		lvl_next = lvl_reg;
		pw_next = 1'b0;
		pa_next = pa_reg;
		pd_next = pd_reg;
		idle_next = idle_reg;
		stop_next = stop_reg;
		ill_next = 1'b0;
		f = fl;
		fwe = 1'b0;
		wen = 1'b0;
		wa = daddr;
		wd = dv;
		r = dv;
		adj = `BYTE_ZERO;
		t = `BYTE_ZERO;
		w = dpair;
		if (state_reg != S_MEM && take) begin
			ack_next = 1'b1;
			lvl_next = irq_level_i;
			idle_next = 1'b0;
			stop_next = 1'b0;
			state_next = S_RUN;
			// fast path chosen by enable bit and level match
			if (fast) begin
				pc_next = ip;
				rf_next[`IPH_ADDR] = pc_reg[15:8];
				rf_next[`IPL_ADDR] = pc_reg[7:0];
				fprime_next = fl;
				f[`F_FIS] = 1'b1;
				fwe = 1'b1;
			end else begin
				rf_next[`SYM_ADDR][`SYM_GIE] = 1'b0;
				rf_next[sp - `BYTE_ONE] = pc_reg[7:0];
				rf_next[sp - `BYTE_TWO] = pc_reg[15:8];
				rf_next[sp - `BYTE_THREE] = fl;
				rf_next[`SP_ADDR] = sp - `BYTE_THREE;
				pc_next = `VEC_BASE + {12'h000, irq_level_i, 1'b0};
			end
		end else begin
			case (state_reg)
			S_MEM: begin
				if (mem_ack_i) begin
					mreq_next = 1'b0;
					if (!mwr_reg) begin
						wen = 1'b1;
						wa = mdst_reg;
						wd = mem_rdata_i;
					end
					state_next = S_RUN;
				end
			end
			S_WAIT: state_next = S_WAIT;
			S_RUN: if (instr_valid_i) begin
				pc_next = pc_reg + `INSTR_BYTES;
				case (op)
				OP_CLR: begin wen = 1'b1; wd = `BYTE_ZERO; end
				OP_LD: begin wen = 1'b1; wd = sv; end
				OP_LDBIT: begin wen = 1'b1; wd = {dv[7:1], bitv}; end
				OP_LDX, OP_LDP, OP_LDX_POSTDEC, OP_LDP_POSTDEC, OP_LDX_POSTINC,
				OP_LDP_POSTINC, OP_LDX_PREDEC, OP_LDP_PREDEC, OP_LDX_PREINC,
				OP_LDP_PREINC: begin
					mprog_next = (op == OP_LDP || op == OP_LDP_POSTDEC ||
						op == OP_LDP_POSTINC || op == OP_LDP_PREDEC ||
						op == OP_LDP_PREINC);
					maddr_next = (op == OP_LDX_PREDEC || op == OP_LDP_PREDEC ||
						op == OP_LDX_PREINC || op == OP_LDP_PREINC) ? ptr : spair;
					rf_next[sra] = ptr[15:8];
					rf_next[sra + `BYTE_ONE] = ptr[7:0];
					mreq_next = 1'b1;
					mwr_next = instr_i[27];
					mwd_next = dv;
					mdst_next = daddr;
					state_next = S_MEM;
				end
				OP_LDWORD: begin
					w = (am == MODE_IMM) ? {src, disp} : spair;
					rf_next[daddr] = w[15:8];
					rf_next[daddr + `BYTE_ONE] = w[7:0];
				end
				OP_POP: begin
					wen = 1'b1;
					wd = rf_reg[sp];
					rf_next[`SP_ADDR] = sp + `BYTE_ONE;
				end
				OP_PUSH: begin
					rf_next[sp - `BYTE_ONE] = sv;
					rf_next[`SP_ADDR] = sp - `BYTE_ONE;
				end
				OP_UPOP_DN, OP_UPOP_UP: begin
					wen = 1'b1;
					wd = rf_reg[rf_reg[sra]];
					rf_next[sra] = (op == OP_UPOP_DN) ?
						rf_reg[sra] - `BYTE_ONE : rf_reg[sra] + `BYTE_ONE;
				end
				OP_UPUSH_DN, OP_UPUSH_UP: begin
					t = (op == OP_UPUSH_DN) ? dv - `BYTE_ONE : dv + `BYTE_ONE;
					rf_next[t] = sv;
					rf_next[daddr] = t;
				end
				OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP: begin
					fwe = 1'b1;
					wen = (op != OP_CMP);
					if (op == OP_ADD || op == OP_ADDC) begin
						r = add9[7:0];
						f[`F_C] = add9[8];
						f[`F_V] = (dv[7] == sv[7]) && (r[7] != dv[7]);
						f[`F_H] = hadd[4];
						f[`F_D] = 1'b0;
					end else begin
						r = sub9[7:0];
						f[`F_C] = sub9[8];
						f[`F_V] = (dv[7] != sv[7]) && (r[7] != dv[7]);
						if (op != OP_CMP) begin
							f[`F_H] = hsub[4];
							f[`F_D] = 1'b1;
						end
					end
					wd = r;
					f[`F_Z] = (r == `BYTE_ZERO);
					f[`F_S] = r[7];
				end
				// decimal adjust from d, h, c
				OP_DECFIX: begin
					if (fl[`F_H] || (!fl[`F_D] && dv[3:0] > `BCD_DIG)) begin
						adj = `BCD_LO;
					end
					if (fl[`F_C] || (!fl[`F_D] && dv > `BCD_MAX)) begin
						adj = adj | `BCD_HI;
						f[`F_C] = 1'b1;
					end
					r = fl[`F_D] ? dv - adj : dv + adj;
					wen = 1'b1;
					wd = r;
					fwe = 1'b1;
					f[`F_Z] = (r == `BYTE_ZERO);
					f[`F_S] = r[7];
				end
				OP_INC, OP_DEC: begin
					r = (op == OP_INC) ? dv + `BYTE_ONE : dv - `BYTE_ONE;
					wen = 1'b1;
					wd = r;
					fwe = 1'b1;
					f[`F_Z] = (r == `BYTE_ZERO);
					f[`F_S] = r[7];
					f[`F_V] = (r[7] != dv[7]) && (dv[7] == (op == OP_DEC));
				end
				OP_WINC, OP_WDEC: begin
					w = (op == OP_WINC) ? dpair + `WORD_ONE : dpair - `WORD_ONE;
					rf_next[daddr] = w[15:8];
					rf_next[daddr + `BYTE_ONE] = w[7:0];
					fwe = 1'b1;
					f[`F_Z] = (w == 16'h0000);
					f[`F_S] = w[15];
					f[`F_V] = (w[15] != dpair[15]) && (dpair[15] == (op == OP_WDEC));
				end
				OP_PRODUCT: begin
					w = {8'h00, rf_reg[daddr + `BYTE_ONE]} * {8'h00, sv};
					rf_next[daddr] = w[15:8];
					rf_next[daddr + `BYTE_ONE] = w[7:0];
					fwe = 1'b1;
					f[`F_Z] = (w == 16'h0000);
					f[`F_S] = w[15];
					f[`F_V] = 1'b0;
				end
				OP_DIVIDE: begin
					fwe = 1'b1;
					f[`F_V] = 1'b1;
					if (sv != `BYTE_ZERO) begin
						w = dpair / {8'h00, sv};
						t = 8'(dpair % {8'h00, sv});
						rf_next[daddr] = t;
						rf_next[daddr + `BYTE_ONE] = w[7:0];
						f[`F_V] = (w[15:8] != `BYTE_ZERO);
						f[`F_Z] = (w == 16'h0000);
						f[`F_S] = w[7];
					end
				end
				OP_AND, OP_OR, OP_XOR, OP_COM, OP_TEST, OP_TESTINV: begin
					case (op)
						OP_AND: r = dv & sv;
						OP_OR: r = dv | sv;
						OP_XOR: r = dv ^ sv;
						OP_COM: r = ~dv;
						OP_TEST: r = dv & sv;
						default: r = ~dv & sv;
					endcase
					wen = (op != OP_TEST && op != OP_TESTINV);
					wd = r;
					fwe = 1'b1;
					f[`F_Z] = (r == `BYTE_ZERO);
					f[`F_S] = r[7];
					f[`F_V] = 1'b0;
				end
				OP_BITJ_F, OP_BITJ_T: if ((dv & mask) != `BYTE_ZERO ==
					(op == OP_BITJ_T)) begin
					pc_next = brt;
				end
				OP_CALL: begin
					rf_next[sp - `BYTE_ONE] = pc_next[7:0];
					rf_next[sp - `BYTE_TWO] = pc_next[15:8];
					rf_next[`SP_ADDR] = sp - `BYTE_TWO;
					pc_next = target;
				end
				OP_CMPJ_EQ, OP_CMPJ_NE: begin
					rf_next[sra] = rf_reg[sra] + `BYTE_ONE;
					if ((dv == rf_reg[rf_reg[sra]]) == (op == OP_CMPJ_EQ)) begin
						pc_next = brt;
					end
				end
				OP_LOOPDN: begin
					wen = 1'b1;
					wd = dv - `BYTE_ONE;
					if (wd != `BYTE_ZERO) begin
						pc_next = brt;
					end
				end
				OP_ENTER: begin
					rf_next[sp - `BYTE_ONE] = ip[7:0];
					rf_next[sp - `BYTE_TWO] = ip[15:8];
					rf_next[`SP_ADDR] = sp - `BYTE_TWO;
					rf_next[`IPH_ADDR] = pc_next[15:8];
					rf_next[`IPL_ADDR] = pc_next[7:0];
				end
				OP_EXIT: begin
					pc_next = ip;
					rf_next[`IPH_ADDR] = rf_reg[sp];
					rf_next[`IPL_ADDR] = rf_reg[sp + `BYTE_ONE];
					rf_next[`SP_ADDR] = sp + `BYTE_TWO;
				end
				OP_NEXT: begin
					w = ip + `INSTR_BYTES;
					pc_next = ip;
					rf_next[`IPH_ADDR] = w[15:8];
					rf_next[`IPL_ADDR] = w[7:0];
				end
				OP_IRET: begin
					fwe = 1'b1;
					if (fl[`F_FIS]) begin
						// pointer left holding the address of this iret
						pc_next = ip;
						rf_next[`IPH_ADDR] = pc_reg[15:8];
						rf_next[`IPL_ADDR] = pc_reg[7:0];
						f = fprime_reg;
						f[`F_FIS] = 1'b0;
					end else begin
						f = rf_reg[sp];
						pc_next = {rf_reg[sp + `BYTE_ONE], rf_reg[sp + `BYTE_TWO]};
						rf_next[`SP_ADDR] = sp + `BYTE_THREE;
						rf_next[`SYM_ADDR][`SYM_GIE] = 1'b1;
					end
				end
				OP_JUMP: if (cond_ok(instr_i[31:28], fl)) pc_next = target;
				OP_JREL: if (cond_ok(instr_i[31:28], fl)) pc_next = brt;
				OP_RET: begin
					pc_next = {rf_reg[sp], rf_reg[sp + `BYTE_ONE]};
					rf_next[`SP_ADDR] = sp + `BYTE_TWO;
				end
				OP_WAITI: state_next = S_WAIT;
				OP_BAND: begin wen = 1'b1; wd = {dv[7:1], dv[0] & bitv}; end
				OP_BOR: begin wen = 1'b1; wd = {dv[7:1], dv[0] | bitv}; end
				OP_BXOR: begin wen = 1'b1; wd = {dv[7:1], dv[0] ^ bitv}; end
				OP_BCMP: begin fwe = 1'b1; f[`F_Z] = ~(dv[0] ^ bitv); end
				OP_BCOM: begin wen = 1'b1; wd = dv ^ mask; end
				OP_BCLR: begin wen = 1'b1; wd = dv & ~mask; end
				OP_BSET: begin wen = 1'b1; wd = dv | mask; end
				OP_ROL, OP_ROLC, OP_ROR, OP_RORC, OP_SHRA, OP_NIBSWAP: begin
					case (op)
						OP_ROL: r = {dv[6:0], dv[7]};
						OP_ROLC: r = {dv[6:0], fl[`F_C]};
						OP_ROR: r = {dv[0], dv[7:1]};
						OP_RORC: r = {fl[`F_C], dv[7:1]};
						OP_SHRA: r = {dv[7], dv[7:1]};
						default: r = {dv[3:0], dv[7:4]};
					endcase
					if (op != OP_NIBSWAP) begin
						f[`F_C] = (op == OP_ROL || op == OP_ROLC) ? dv[7] : dv[0];
						f[`F_V] = r[7] ^ dv[7];
					end
					wen = 1'b1;
					wd = r;
					fwe = 1'b1;
					f[`F_Z] = (r == `BYTE_ZERO);
					f[`F_S] = r[7];
				end
				OP_CCF: begin fwe = 1'b1; f[`F_C] = ~fl[`F_C]; end
				OP_RCF: begin fwe = 1'b1; f[`F_C] = 1'b0; end
				OP_SCF: begin fwe = 1'b1; f[`F_C] = 1'b1; end
				OP_INTOFF: rf_next[`SYM_ADDR][`SYM_GIE] = 1'b0;
				OP_INTON: rf_next[`SYM_ADDR][`SYM_GIE] = 1'b1;
				OP_IDLE: begin idle_next = 1'b1; state_next = S_WAIT; end
				OP_STOP: begin stop_next = 1'b1; state_next = S_WAIT; end
				OP_NOP: fwe = 1'b0;
				OP_BANK0: begin fwe = 1'b1; f[`F_BA] = 1'b0; end
				OP_BANK1: begin fwe = 1'b1; f[`F_BA] = 1'b1; end
				OP_SETRP: begin
					rf_next[`RP0_ADDR] = sv & `RP_PAIR_MASK;
					rf_next[`RP1_ADDR] = (sv & `RP_PAIR_MASK) | `RP_HALF;
				end
				OP_SETRP0: rf_next[`RP0_ADDR] = sv & `RP_MASK;
				OP_SETRP1: rf_next[`RP1_ADDR] = sv & `RP_MASK;
				default: ill_next = 1'b1;
				endcase
			end
			default: state_next = S_RUN;
			endcase
		end
		if (fwe) begin
			rf_next[`FLAGS_ADDR] = f;
		end
		if (wen) begin
			rf_next[wa] = wd;
		end
		if (wen && wa >= `PERIPH_BASE) begin
			pw_next = 1'b1;
			pa_next = wa;
			pd_next = wd;
		end
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < `RF_WORDS; i++) begin
				rf_reg[i] <= `BYTE_ZERO;
			end
			rf_reg[`RP0_ADDR] <= `RP0_RESET;
			rf_reg[`RP1_ADDR] <= `RP1_RESET;
			state_reg <= S_RUN;
			pc_reg <= `RESET_PC;
			fprime_reg <= `BYTE_ZERO;
			mreq_reg <= 1'b0;
			mwr_reg <= 1'b0;
			mprog_reg <= 1'b0;
			maddr_reg <= 16'h0000;
			mwd_reg <= `BYTE_ZERO;
			mdst_reg <= `BYTE_ZERO;
			ack_reg <= 1'b0;
			lvl_reg <= 3'h0;
			pw_reg <= 1'b0;
			pa_reg <= `BYTE_ZERO;
			pd_reg <= `BYTE_ZERO;
			idle_reg <= 1'b0;
			stop_reg <= 1'b0;
			ill_reg <= 1'b0;
		end else begin
			rf_reg <= rf_next;
			state_reg <= state_next;
			pc_reg <= pc_next;
			fprime_reg <= fprime_next;
			mreq_reg <= mreq_next;
			mwr_reg <= mwr_next;
			mprog_reg <= mprog_next;
			maddr_reg <= maddr_next;
			mwd_reg <= mwd_next;
			mdst_reg <= mdst_next;
			ack_reg <= ack_next;
			lvl_reg <= lvl_next;
			pw_reg <= pw_next;
			pa_reg <= pa_next;
			pd_reg <= pd_next;
			idle_reg <= idle_next;
			stop_reg <= stop_next;
			ill_reg <= ill_next;
		end
	end

	assign pc_o = pc_reg;
	assign mem_req_o = mreq_reg;
	assign mem_write_o = mwr_reg;
	assign mem_prog_o = mprog_reg;
	assign mem_addr_o = maddr_reg;
	assign mem_wdata_o = mwd_reg;
	assign irq_ack_o = ack_reg;
	assign irq_ack_level_o = lvl_reg;
	assign periph_wr_o = pw_reg;
	assign periph_addr_o = pa_reg;
	assign periph_wdata_o = pd_reg;
	assign idle_o = idle_reg;
	assign stop_o = stop_reg;
	assign illegal_o = ill_reg;
endmodule // mcu_instruction_set_core
`default_nettype wire
